// ===== hdl/hupc_consts.vh
// Constants for the hub upstream port control block.
// Assumes the link layer reports its state in the HUPC_LS_* encoding.
// Contract
// (R1) Port machine resets to unpowered and holds link in SS.Disabled there.
// (R2) Port goes unpowered on VBUS loss, lost terminations, or failed configuration.
// (R3) Port enters detecting from unpowered, fault warm reset, any reset, polling timeout.
// (R4) Detecting state holds link in Rx.Detect.
// (R5) Detected terminations move detecting to training; link in Polling while training.
// (R6) Polling.Idle to U0 moves training to configuring; start configuration on entry.
// (R7) Configuring sends only link packets, link commands, default control responses.
// (R8) Recovery timeout in configuring or addressed goes to fault, link SS.Inactive.
// (R9) Fault state is left only by a warm reset; the code also leaves it for unpowered on VBUS loss or lost terminations.
// (R10) Acknowledged Set Address status moves configuring to addressed.
// (R11) Addressed entered in U0; later any link state, any packet type allowed.
// (R12) High-speed connect logic runs independently of USB 2.0 connect logic.
// (R13) Connect machine resets unpowered, returns on VBUS loss, link SS.Disabled there.
// (R14) Connect attempt entered on VBUS plus local power, or link detect/training timeout.
// (R15) Connect attempt becomes connected when link goes Polling to U0.
// (R16) Downstream status change while link in U1 or U2 requests U0.
// (R17) Downstream status change in U3 wakes only if remote wakeup mask allows.
// (R18) One PM timer tracks only U2 inactivity; no U1 timeout.
// (R19) U2 inactivity timeout loads on each received U2 timeout packet.
// (R20) PM timer clears whenever the link enters U1.
// (R21) PM timer error at most 500 us late, never early.
// (R22) In U1, timer reaching timeout other than 0xff or 0x00 requests U2.
// (R23) Both machines registered on hub clock; synchronous reset forces unpowered.
`ifndef HUPC_CONSTS_VH
`define HUPC_CONSTS_VH

// Link state encoding
`define HUPC_LS_W        4
`define HUPC_LS_DISABLED 4'h0
`define HUPC_LS_RXDET    4'h1
`define HUPC_LS_POLLING  4'h2
`define HUPC_LS_U0       4'h3
`define HUPC_LS_U1       4'h4
`define HUPC_LS_U2       4'h5
`define HUPC_LS_U3       4'h6
`define HUPC_LS_RECOVERY 4'h7
`define HUPC_LS_INACTIVE 4'h8

// Port machine states
`define HUPC_PS_W        3
`define HUPC_PS_UNPWR    3'h0
`define HUPC_PS_DETECT   3'h1
`define HUPC_PS_TRAIN    3'h2
`define HUPC_PS_CONFIG   3'h3
`define HUPC_PS_FAULT    3'h4
`define HUPC_PS_ADDR     3'h5

// Connect machine states
`define HUPC_HS_W        2
`define HUPC_HS_UNPWR    2'h0
`define HUPC_HS_ATTEMPT  2'h1
`define HUPC_HS_LINKED   2'h2

// U2 inactivity timeout
`define HUPC_TO_W        8
`define HUPC_TO_OFF      8'hff
`define HUPC_TO_ZERO     8'h00
`define HUPC_TO_RESET    8'h00

// Timing
`define HUPC_CLK_MHZ     100
`define HUPC_UNIT_US     256
`define HUPC_LATE_MAX_US 500
`define HUPC_PRE_W       24

`endif

// ===== hdl/hupc_top.v
// Hub upstream port control: port machine, connect machine, upstream
// link power requests and the U2 inactivity PM timer.
// Assumes link events are one-cycle pulses on clk_i; VBUS and local
// power arrive from pins and are synchronised here.
`include "hupc_consts.vh"

module hupc_top #(
  // Clock cycles per U2 timeout unit
  parameter UNIT_CYCLES = `HUPC_UNIT_US * `HUPC_CLK_MHZ
) (
  // Clock and reset
  input  wire                    clk_i,
  input  wire                    rst_n_i,
  // Power pins
  input  wire                    vbus_valid_i,
  input  wire                    local_pwr_valid_i,
  input  wire                    local_pwr_needed_i,
  // Link layer status
  input  wire [`HUPC_LS_W-1:0]   link_state_i,
  input  wire                    term_detected_i,
  input  wire                    term_lost_i,
  input  wire                    polling_timeout_i,
  input  wire                    rxdet_timeout_i,
  input  wire                    recovery_timeout_i,
  input  wire                    warm_reset_i,
  input  wire                    any_reset_i,
  // Configuration and protocol events
  input  wire                    cfg_failed_i,
  input  wire                    set_addr_acked_i,
  input  wire                    u2_lmp_valid_i,
  input  wire [`HUPC_TO_W-1:0]   u2_lmp_timeout_i,
  // Downstream ports
  input  wire                    ds_status_change_i,
  input  wire                    wake_mask_allows_i,
  // Machine states
  output reg  [`HUPC_PS_W-1:0]   port_state_o,
  output reg  [`HUPC_HS_W-1:0]   hub_conn_state_o,
  // Link commands
  output reg  [`HUPC_LS_W-1:0]   port_link_target_o,
  output reg  [`HUPC_LS_W-1:0]   hub_link_target_o,
  output reg                     cfg_start_o,
  output reg                     tx_limited_o,
  output reg                     tx_any_o,
  // Power management requests
  output reg                     req_u0_o,
  output reg                     req_u2_o,
  output reg                     remote_wake_o,
  output reg  [`HUPC_TO_W-1:0]   u2_timeout_o
);

  // Pin synchronisers
  reg  vbus_meta;
  reg  vbus_s;
  reg  lpwr_meta;
  reg  lpwr_s;

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      vbus_meta <= 1'b0;
      vbus_s    <= 1'b0;
      lpwr_meta <= 1'b0;
      lpwr_s    <= 1'b0;
    end else begin
      vbus_meta <= vbus_valid_i;
      vbus_s    <= vbus_meta;
      lpwr_meta <= local_pwr_valid_i;
      lpwr_s    <= lpwr_meta;
    end
  end

  // Link state history
  reg  [`HUPC_LS_W-1:0] link_prev;
  wire                  poll_to_u0;
  wire                  u1_entry;
  wire                  link_in_u0;

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      link_prev <= `HUPC_LS_DISABLED;
    end else begin
      link_prev <= link_state_i;
    end
  end

  assign poll_to_u0 = (link_prev == `HUPC_LS_POLLING) && (link_state_i == `HUPC_LS_U0);
  assign u1_entry   = (link_prev != `HUPC_LS_U1) && (link_state_i == `HUPC_LS_U1);
  assign link_in_u0 = (link_state_i == `HUPC_LS_U0);

  // Port machine
  reg  [`HUPC_PS_W-1:0] port_state;
  reg  [`HUPC_PS_W-1:0] next_port_state;

  always @* begin
    next_port_state = port_state;
    case (port_state)
      `HUPC_PS_UNPWR: begin
        if (vbus_s) begin
          next_port_state = `HUPC_PS_DETECT; // R3
        end
      end
      `HUPC_PS_DETECT: begin
        if (term_detected_i) begin
          next_port_state = `HUPC_PS_TRAIN; // R5
        end
      end
      `HUPC_PS_TRAIN: begin
        if (polling_timeout_i) begin
          next_port_state = `HUPC_PS_DETECT; // R3
        end else if (poll_to_u0) begin
          next_port_state = `HUPC_PS_CONFIG; // R6
        end
      end
      `HUPC_PS_CONFIG: begin
        if (cfg_failed_i) begin
          next_port_state = `HUPC_PS_UNPWR; // R2
        end else if (any_reset_i) begin
          next_port_state = `HUPC_PS_DETECT; // R3
        end else if (recovery_timeout_i) begin
          next_port_state = `HUPC_PS_FAULT; // R8
        end else if (set_addr_acked_i && link_in_u0) begin
          // Addressed only entered with the link in U0
          next_port_state = `HUPC_PS_ADDR; // R10 R11
        end
      end
      `HUPC_PS_FAULT: begin
        if (warm_reset_i) begin
          next_port_state = `HUPC_PS_DETECT; // R9
        end
      end
      `HUPC_PS_ADDR: begin
        if (any_reset_i) begin
          next_port_state = `HUPC_PS_DETECT; // R3
        end else if (recovery_timeout_i) begin
          next_port_state = `HUPC_PS_FAULT; // R8
        end
      end
      default: begin
        next_port_state = `HUPC_PS_UNPWR;
      end
    endcase
    // Power or termination loss overrides everything
    if (!vbus_s || term_lost_i) begin
      next_port_state = `HUPC_PS_UNPWR; // R2
    end
  end

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      port_state <= `HUPC_PS_UNPWR; // R1 R23
    end else begin
      port_state <= next_port_state;
    end
  end

  // Link target for each port state
  reg  [`HUPC_LS_W-1:0] next_port_link;

  always @* begin
    case (next_port_state)
      `HUPC_PS_UNPWR:  next_port_link = `HUPC_LS_DISABLED; // R1
      `HUPC_PS_DETECT: next_port_link = `HUPC_LS_RXDET; // R4
      `HUPC_PS_TRAIN:  next_port_link = `HUPC_LS_POLLING; // R5
      `HUPC_PS_CONFIG: next_port_link = `HUPC_LS_U0; // R6
      `HUPC_PS_FAULT:  next_port_link = `HUPC_LS_INACTIVE; // R8
      `HUPC_PS_ADDR:   next_port_link = `HUPC_LS_U0; // R11
      default:         next_port_link = `HUPC_LS_DISABLED;
    endcase
  end

  // Connect machine, independent of any USB 2.0 connect path
  reg  [`HUPC_HS_W-1:0] hub_state;
  reg  [`HUPC_HS_W-1:0] next_hub_state;
  wire                  pwr_ok;

  assign pwr_ok = vbus_s && (lpwr_s || !local_pwr_needed_i); // R12

  always @* begin
    next_hub_state = hub_state;
    case (hub_state)
      `HUPC_HS_UNPWR: begin
        if (pwr_ok) begin
          next_hub_state = `HUPC_HS_ATTEMPT; // R14
        end
      end
      `HUPC_HS_ATTEMPT: begin
        if (poll_to_u0) begin
          next_hub_state = `HUPC_HS_LINKED; // R15
        end
      end
      `HUPC_HS_LINKED: begin
        if (rxdet_timeout_i || polling_timeout_i) begin
          next_hub_state = `HUPC_HS_ATTEMPT; // R14
        end
      end
      default: begin
        next_hub_state = `HUPC_HS_UNPWR;
      end
    endcase
    if (!vbus_s) begin
      next_hub_state = `HUPC_HS_UNPWR; // R13
    end
  end

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      hub_state <= `HUPC_HS_UNPWR; // R13 R23
    end else begin
      hub_state <= next_hub_state;
    end
  end

  // Connect machine link target
  reg  [`HUPC_LS_W-1:0] next_hub_link;

  always @* begin
    case (next_hub_state)
      `HUPC_HS_UNPWR:   next_hub_link = `HUPC_LS_DISABLED; // R13
      `HUPC_HS_ATTEMPT: next_hub_link = `HUPC_LS_RXDET; // R14
      `HUPC_HS_LINKED:  next_hub_link = link_state_i; // R15
      default:          next_hub_link = `HUPC_LS_DISABLED;
    endcase
  end

  // U2 inactivity timeout value
  reg  [`HUPC_TO_W-1:0] u2_timeout;

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      u2_timeout <= `HUPC_TO_RESET;
    end else if (u2_lmp_valid_i) begin
      u2_timeout <= u2_lmp_timeout_i; // R19
    end
  end

  // PM timer: prescaler restarts on U1 entry, so no unit is short and
  // expiry is never early; it lands two cycles after the last full unit.
  // Unit count runs on to saturation, independent of the timeout, so a
  // timeout loaded mid-U1 is judged against the real time spent there.
  reg  [`HUPC_PRE_W-1:0] pre_cnt;
  reg  [`HUPC_TO_W-1:0]  pm_units;
  reg                    pm_fired;
  wire                   unit_tick;
  wire                   in_u1;
  wire                   timeout_armed;
  wire                   pm_reached;
  wire                   pm_saturated;
  wire                   pm_expire;

  assign in_u1         = (link_state_i == `HUPC_LS_U1);
  assign unit_tick     = (pre_cnt == UNIT_CYCLES[`HUPC_PRE_W-1:0] - 1'b1); // R21
  assign timeout_armed = (u2_timeout != `HUPC_TO_OFF) && (u2_timeout != `HUPC_TO_ZERO);
  assign pm_reached    = (pm_units >= u2_timeout);
  assign pm_saturated  = (pm_units == {`HUPC_TO_W{1'b1}});
  assign pm_expire     = in_u1 && !u1_entry && timeout_armed && !pm_fired &&
                         pm_reached; // R22

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      pre_cnt  <= {`HUPC_PRE_W{1'b0}};
      pm_units <= {`HUPC_TO_W{1'b0}};
      pm_fired <= 1'b0;
    end else if (u1_entry || !in_u1) begin
      pre_cnt  <= {`HUPC_PRE_W{1'b0}}; // R20
      pm_units <= {`HUPC_TO_W{1'b0}}; // R18 R20
      pm_fired <= 1'b0;
    end else begin
      if (pm_expire) begin
        pm_fired <= 1'b1;
      end
      if (unit_tick) begin
        pre_cnt <= {`HUPC_PRE_W{1'b0}};
        if (!pm_saturated) begin
          pm_units <= pm_units + 1'b1; // R21
        end
      end else begin
        pre_cnt <= pre_cnt + 1'b1;
      end
    end
  end

  // Downstream status change handling
  wire in_u1_u2;
  wire in_u3;
  wire ds_wake_u0;
  wire ds_wake_u3;

  assign in_u1_u2   = in_u1 || (link_state_i == `HUPC_LS_U2);
  assign in_u3      = (link_state_i == `HUPC_LS_U3);
  assign ds_wake_u0 = ds_status_change_i && in_u1_u2; // R16
  assign ds_wake_u3 = ds_status_change_i && in_u3 && wake_mask_allows_i; // R17

  // Next values of the permission and request outputs
  wire next_cfg_start;
  wire next_tx_limited;
  wire next_tx_any;
  wire next_req_u2;

  assign next_cfg_start  = (next_port_state == `HUPC_PS_CONFIG) &&
                           (port_state != `HUPC_PS_CONFIG); // R6
  assign next_tx_limited = (next_port_state == `HUPC_PS_CONFIG); // R7
  assign next_tx_any     = (next_port_state == `HUPC_PS_ADDR); // R11
  // Wake to U0 wins; a U2 request in that cycle would fight it
  assign next_req_u2     = pm_expire && !ds_wake_u0; // R22

  // State, link target and timeout outputs
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      port_state_o       <= `HUPC_PS_UNPWR;
      hub_conn_state_o   <= `HUPC_HS_UNPWR;
      port_link_target_o <= `HUPC_LS_DISABLED;
      hub_link_target_o  <= `HUPC_LS_DISABLED;
      u2_timeout_o       <= `HUPC_TO_RESET;
    end else begin
      port_state_o       <= next_port_state;
      hub_conn_state_o   <= next_hub_state;
      port_link_target_o <= next_port_link;
      hub_link_target_o  <= next_hub_link;
      u2_timeout_o       <= u2_lmp_valid_i ? u2_lmp_timeout_i : u2_timeout; // R19
    end
  end

  // Transmit permission outputs
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      cfg_start_o  <= 1'b0;
      tx_limited_o <= 1'b0;
      tx_any_o     <= 1'b0;
    end else begin
      cfg_start_o  <= next_cfg_start;
      tx_limited_o <= next_tx_limited;
      tx_any_o     <= next_tx_any;
    end
  end

  // Link power request outputs, one-cycle pulses
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      req_u0_o      <= 1'b0;
      req_u2_o      <= 1'b0;
      remote_wake_o <= 1'b0;
    end else begin
      req_u0_o      <= ds_wake_u0; // R16
      req_u2_o      <= next_req_u2;
      remote_wake_o <= ds_wake_u3; // R17
    end
  end

endmodule // hupc_top

// ===== tb/hupc_link_partner.sv
// Upstream link partner model: the link state seen by the hub port.
// Assumes the bench commands state changes; it answers PM requests itself.
`include "hupc_consts.vh"
module hupc_link_partner (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       set_i,
  input  wire logic [3:0] set_state_i,
  input  wire logic       req_u0_i,
  input  wire logic       req_u2_i,
  output logic      [3:0] link_state_o
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge clk_i) begin
    if (!rst_n_i) link_state_o <= `HUPC_LS_DISABLED;
    else if (set_i) link_state_o <= set_state_i;
    else if (req_u0_i) link_state_o <= `HUPC_LS_U0;
    else if (req_u2_i && link_state_o == `HUPC_LS_U1) link_state_o <= `HUPC_LS_U2;
  end
endmodule // hupc_link_partner

// ===== tb/hupc_monitor.sv
// Concurrent checks on the hub upstream port control block.
// Assumes it is bound to hupc_top and sees that module's ports only.
`include "hupc_consts.vh"
module hupc_monitor #(
  parameter UNIT_CYCLES = `HUPC_UNIT_US * `HUPC_CLK_MHZ
) (
  input wire logic                  clk_i,
  input wire logic                  rst_n_i,
  input wire logic                  vbus_valid_i,
  input wire logic [`HUPC_LS_W-1:0] link_state_i,
  input wire logic                  term_lost_i,
  input wire logic                  warm_reset_i,
  input wire logic                  set_addr_acked_i,
  input wire logic                  u2_lmp_valid_i,
  input wire logic [`HUPC_TO_W-1:0] u2_lmp_timeout_i,
  input wire logic                  ds_status_change_i,
  input wire logic                  wake_mask_allows_i,
  input wire logic [`HUPC_PS_W-1:0] port_state_o,
  input wire logic [`HUPC_HS_W-1:0] hub_conn_state_o,
  input wire logic [`HUPC_LS_W-1:0] port_link_target_o,
  input wire logic                  cfg_start_o,
  input wire logic                  tx_limited_o,
  input wire logic                  tx_any_o,
  input wire logic                  req_u0_o,
  input wire logic                  req_u2_o,
  input wire logic                  remote_wake_o,
  input wire logic [`HUPC_TO_W-1:0] u2_timeout_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Consecutive cycles spent in U1
  int u1_cycles;
  always @(posedge clk_i) u1_cycles <= (link_state_i == `HUPC_LS_U1) ? u1_cycles + 1 : 0;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_unpwr_link;
    port_state_o == `HUPC_PS_UNPWR |-> port_link_target_o == `HUPC_LS_DISABLED;
  endproperty
  a_unpwr_link: assert property (p_unpwr_link) else $error("link not disabled");
  property p_detect_link;
    port_state_o == `HUPC_PS_DETECT |-> port_link_target_o == `HUPC_LS_RXDET;
  endproperty
  a_detect_link: assert property (p_detect_link) else $error("link not rx detect");
  property p_train_link;
    port_state_o == `HUPC_PS_TRAIN |-> port_link_target_o == `HUPC_LS_POLLING;
  endproperty
  a_train_link: assert property (p_train_link) else $error("link not polling");
  property p_fault_link;
    port_state_o == `HUPC_PS_FAULT |-> port_link_target_o == `HUPC_LS_INACTIVE;
  endproperty
  a_fault_link: assert property (p_fault_link) else $error("link not inactive");
  property p_fault_exit;
    (port_state_o == `HUPC_PS_FAULT) ##1 (port_state_o != `HUPC_PS_FAULT) |->
      port_state_o == `HUPC_PS_UNPWR ||
      (port_state_o == `HUPC_PS_DETECT && $past(warm_reset_i));
  endproperty
  a_fault_exit: assert property (p_fault_exit) else $error("fault left wrongly");
  property p_term_lost;
    term_lost_i |=> port_state_o == `HUPC_PS_UNPWR;
  endproperty
  a_term_lost: assert property (p_term_lost) else $error("no unpowered on loss");
  property p_vbus_loss;
    $fell(vbus_valid_i) |-> ##[1:4]
      (port_state_o == `HUPC_PS_UNPWR && hub_conn_state_o == `HUPC_HS_UNPWR);
  endproperty
  a_vbus_loss: assert property (p_vbus_loss) else $error("vbus loss ignored");
  property p_cfg_entry;
    cfg_start_o |-> port_state_o == `HUPC_PS_CONFIG && tx_limited_o &&
      $past(port_state_o) == `HUPC_PS_TRAIN;
  endproperty
  a_cfg_entry: assert property (p_cfg_entry) else $error("bad config start");
  property p_addr_entry;
    port_state_o == `HUPC_PS_ADDR && $past(port_state_o) == `HUPC_PS_CONFIG |->
      $past(set_addr_acked_i) && $past(link_state_i) == `HUPC_LS_U0 && tx_any_o;
  endproperty
  a_addr_entry: assert property (p_addr_entry) else $error("bad address entry");
  property p_limited;
    tx_limited_o |-> port_state_o == `HUPC_PS_CONFIG && !tx_any_o;
  endproperty
  a_limited: assert property (p_limited) else $error("limited out of config");
  property p_ds_u0;
    ds_status_change_i && (link_state_i == `HUPC_LS_U1 || link_state_i == `HUPC_LS_U2)
      |=> req_u0_o;
  endproperty
  a_ds_u0: assert property (p_ds_u0) else $error("no U0 request");
  property p_ds_wake;
    ds_status_change_i && link_state_i == `HUPC_LS_U3 |=>
      remote_wake_o == $past(wake_mask_allows_i);
  endproperty
  a_ds_wake: assert property (p_ds_wake) else $error("wake not per mask");
  property p_lmp_load;
    u2_lmp_valid_i |=> u2_timeout_o == $past(u2_lmp_timeout_i);
  endproperty
  a_lmp_load: assert property (p_lmp_load) else $error("timeout not loaded");
  property p_u2_early;
    req_u2_o |-> u1_cycles >= u2_timeout_o * UNIT_CYCLES &&
      u2_timeout_o != `HUPC_TO_OFF && u2_timeout_o != `HUPC_TO_ZERO;
  endproperty
  a_u2_early: assert property (p_u2_early) else $error("U2 request early");
  c_addr: cover property (port_state_o == `HUPC_PS_ADDR);
  c_fault: cover property (port_state_o == `HUPC_PS_FAULT);
  c_u2: cover property (req_u2_o);
  c_wake: cover property (remote_wake_o);
endmodule // hupc_monitor

bind hupc_top hupc_monitor #(.UNIT_CYCLES(UNIT_CYCLES)) i_mon (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .vbus_valid_i(vbus_valid_i),
  .link_state_i(link_state_i), .term_lost_i(term_lost_i), .warm_reset_i(warm_reset_i),
  .set_addr_acked_i(set_addr_acked_i), .u2_lmp_valid_i(u2_lmp_valid_i),
  .u2_lmp_timeout_i(u2_lmp_timeout_i), .ds_status_change_i(ds_status_change_i),
  .wake_mask_allows_i(wake_mask_allows_i), .port_state_o(port_state_o),
  .hub_conn_state_o(hub_conn_state_o), .port_link_target_o(port_link_target_o),
  .cfg_start_o(cfg_start_o), .tx_limited_o(tx_limited_o), .tx_any_o(tx_any_o),
  .req_u0_o(req_u0_o), .req_u2_o(req_u2_o), .remote_wake_o(remote_wake_o),
  .u2_timeout_o(u2_timeout_o));

// ===== tb/tb_top.sv
// Testbench of the hub upstream port control block.
// Assumes a link partner model and the bound checker beside the design.
`include "hupc_consts.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam UNIT = 4;
  logic        clk_i = 0, rst_n_i = 0, vbus = 0, mask = 0, set = 0;
  logic        lpwr = 1, lneed = 0;
  logic [3:0]  set_st = 0;
  logic [7:0]  lmp_to = 0;
  logic [10:0] ev = 0;
  wire  [3:0]  link, plt, hlt;
  wire  [2:0]  ps;
  wire  [1:0]  hs;
  wire  [7:0]  to;
  wire         cfg_s, lim, any, u0, u2, wake;
  int          miscompares = 0, samples_checked = 0;
  hupc_top #(.UNIT_CYCLES(UNIT)) i_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .vbus_valid_i(vbus), .local_pwr_valid_i(lpwr),
    .local_pwr_needed_i(lneed), .link_state_i(link), .term_detected_i(ev[0]),
    .term_lost_i(ev[1]), .polling_timeout_i(ev[2]), .rxdet_timeout_i(ev[3]),
    .recovery_timeout_i(ev[4]), .warm_reset_i(ev[5]), .any_reset_i(ev[6]),
    .cfg_failed_i(ev[7]), .set_addr_acked_i(ev[8]), .u2_lmp_valid_i(ev[9]),
    .u2_lmp_timeout_i(lmp_to), .ds_status_change_i(ev[10]), .wake_mask_allows_i(mask),
    .port_state_o(ps), .hub_conn_state_o(hs), .port_link_target_o(plt),
    .hub_link_target_o(hlt), .cfg_start_o(cfg_s), .tx_limited_o(lim), .tx_any_o(any),
    .req_u0_o(u0), .req_u2_o(u2), .remote_wake_o(wake), .u2_timeout_o(to));
  hupc_link_partner i_partner (.clk_i(clk_i), .rst_n_i(rst_n_i), .set_i(set),
    .set_state_i(set_st), .req_u0_i(u0), .req_u2_i(u2), .link_state_o(link));
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic pulse(logic [10:0] m);
    @(negedge clk_i) ev = m;
    @(negedge clk_i) ev = 0;
  endtask
  task automatic go(logic [3:0] s);
    @(negedge clk_i) begin
      set = 1;
      set_st = s;
    end
    @(negedge clk_i) set = 0;
  endtask
  task automatic bring_up;
    int n;
    @(negedge clk_i) vbus = 0;
    repeat (5) @(negedge clk_i);
    check("port_state", ps, 0);
    check("hub_conn", hs, 0);
    check("port_link", plt, 0);
    vbus = 1;
    for (n = 0; n < 8 && ps !== 1; n++) @(negedge clk_i);
    check("port_state", ps, 1);
    check("port_link", plt, 1);
    check("hub_conn", hs, 1);
    check("hub_link", hlt, 1);
    pulse(11'h001);
    check("port_state", ps, 2);
    check("port_link", plt, 2);
    go(2);
    go(3);
    @(negedge clk_i);
    check("port_state", ps, 3);
    check("cfg_start", cfg_s, 1);
    check("tx_limited", lim, 1);
    check("hub_conn", hs, 2);
    check("hub_link", hlt, 3);
    @(negedge clk_i);
    check("cfg_start", cfg_s, 0);
    pulse(11'h100);
    check("port_state", ps, 5);
    check("tx_any", any, 1);
  endtask
  task automatic local_power;
    @(negedge clk_i) begin
      vbus = 1;
      lpwr = 0;
      lneed = 1;
    end
    repeat (4) @(negedge clk_i);
    check("port_state", ps, 1);
    check("hub_conn", hs, 0);
    check("hub_link", hlt, 0);
    lpwr = 1;
    repeat (4) @(negedge clk_i);
    check("hub_conn", hs, 1);
    check("hub_link", hlt, 1);
    lneed = 0;
  endtask
  task automatic fault_path;
    bring_up();
    go(7);
    pulse(11'h010);
    check("port_state", ps, 4);
    check("port_link", plt, 8);
    check("hub_link", hlt, 7);
    pulse(11'h140);
    check("port_state", ps, 4);
    pulse(11'h060);
    check("port_state", ps, 1);
  endtask
  task automatic reset_paths;
    bring_up();
    pulse(11'h040);
    check("port_state", ps, 1);
    pulse(11'h001);
    pulse(11'h004);
    check("port_state", ps, 1);
    check("hub_conn", hs, 1);
    pulse(11'h001);
    go(2);
    go(3);
    go(7);
    pulse(11'h100);
    check("port_state", ps, 3);
    pulse(11'h080);
    check("port_state", ps, 0);
    @(negedge clk_i) rst_n_i = 0;
    @(negedge clk_i) rst_n_i = 1;
    check("port_state", ps, 0);
    check("hub_conn", hs, 0);
    @(negedge clk_i);
    check("port_state", ps, 0);
  endtask
  task automatic pm_timer;
    int n;
    bring_up();
    @(negedge clk_i) lmp_to = 8'h03;
    pulse(11'h200);
    check("u2_timeout", to, 8'h03);
    go(4);
    repeat (8) @(negedge clk_i);
    go(3);
    go(4);
    for (n = 0; n < 40 && u2 !== 1; n++) @(negedge clk_i);
    check("u2_window", 8'(n >= 3 * UNIT && n <= 5 * UNIT + 2), 1);
    @(negedge clk_i);
    check("req_u2", u2, 0);
    pulse(11'h400);
    check("req_u0", u0, 1);
    go(6);
    mask = 1;
    pulse(11'h400);
    check("wake", wake, 1);
    mask = 0;
    pulse(11'h400);
    check("wake", wake, 0);
    for (int i = 0; i < 2; i++) begin
      @(negedge clk_i) lmp_to = i ? 8'h00 : 8'hff;
      pulse(11'h200);
      go(3);
      go(4);
      for (n = 0; n < 30 && u2 !== 1; n++) @(negedge clk_i);
      check("u2_disabled", 8'(n), 30);
    end
    pulse(11'h002);
    check("port_state", ps, 0);
  endtask
  task automatic finish_test;
    $display("Comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial forever #5 clk_i = ~clk_i;
  initial begin
    repeat (12) @(negedge clk_i);
    rst_n_i = 1;
    check("port_state", ps, 0);
    check("hub_conn", hs, 0);
    check("port_link", plt, 0);
    check("hub_link", hlt, 0);
    check("u2_timeout", to, 0);
    local_power();
    fault_path();
    reset_paths();
    pm_timer();
    finish_test();
  end
  initial begin
    #100us;
    miscompares++;
    finish_test();
  end
endmodule // tb_top
